/* inc/temp_limit_map.svh */
`ifndef TEMP_LIMIT_MAP_SVH
`define TEMP_LIMIT_MAP_SVH
// register addresses
`define ADDR_LOCAL_VAL 8'h00
`define ADDR_REMOTE_VAL_HI 8'h01
`define ADDR_STATUS 8'h02
`define ADDR_CFG_RD 8'h03
`define ADDR_CFG_WR 8'h09
`define ADDR_LOCAL_HIGH_FLAG_RD 8'h05
`define ADDR_LOCAL_HIGH_FLAG_WR 8'h0B
`define ADDR_LOCAL_LOW_FLAG_RD 8'h06
`define ADDR_LOCAL_LOW_FLAG_WR 8'h0C
`define ADDR_REMOTE_HIGH_FLAG_HI_RD 8'h07
`define ADDR_REMOTE_HIGH_FLAG_HI_WR 8'h0D
`define ADDR_REMOTE_LOW_FLAG_HI_RD 8'h08
`define ADDR_REMOTE_LOW_FLAG_HI_WR 8'h0E
`define ADDR_ONE_SHOT 8'h0F
`define ADDR_REMOTE_VAL_LO 8'h10
`define ADDR_OFS_HI 8'h11
`define ADDR_OFS_LO 8'h12
`define ADDR_REMOTE_HIGH_FLAG_LO 8'h13
`define ADDR_REMOTE_LOW_FLAG_LO 8'h14
`define ADDR_RTHERM 8'h19
`define ADDR_LTHERM 8'h20
`define ADDR_HYST 8'h21
// reset values
`define RST_ZERO 8'h00
`define RST_HIGH_LIMIT 8'h55
`define RST_OVERTEMP_OUT_N_LIMIT 8'h55
`define RST_HYST 8'h0A
// configuration fields
`define CFG_MASK_BIT 7
`define CFG_STANDBY_BIT 6
`define CFG_ROLE_BIT 5
`define CFG_RANGE_BIT 2
`define CFG_USED 8'hE4
// status fields
`define STS_BUSY 7
`define STS_LOCAL_HIGH_FLAG 6
`define STS_LOCAL_LOW_FLAG 5
`define STS_REMOTE_HIGH_FLAG 4
`define STS_REMOTE_LOW_FLAG 3
`define STS_OPEN 2
`define STS_RTRIP 1
`define STS_LTRIP 0
// quarter-degree fraction lives in the top two bits
`define FRAC_MASK 8'hC0
`define REMOTE_MAX_BIN 12'h1FF
`define REMOTE_MAX_EXT 12'h3FF
`endif

/* inc/temp_limit_pkg.sv */
package temp_limit_pkg;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;
   typedef struct packed {
      logic valid;
      logic [7:0] temp;
   } local_sample_s;
   typedef struct packed {
      logic valid;
      logic open;
      logic [9:0] temp;
   } remote_sample_s;
   typedef enum logic [1:0] {
      ALM_IDLE = 2'b01,
      ALM_SET = 2'b10
   } alarm_state_e;
endpackage

/* logic/temp_limit_alarm_status.sv */
`timescale 1ns/1ps
`include "temp_limit_map.svh"
// Function
// - high is strictly greater, low is less-or-equal
// - either over-temperature trip drives overtemp pin low
// - second role: high-limit excess drives pin low
// - one hysteresis, default ten degrees, writable
// - limits stored raw, never converted on rescale
// - status bit 7 shows conversion busy
// - status bits 6..2 hold limit/open flags
// - any sticky flag sets alarm latch; pin low in alarm role unless masked
// - flags sticky; read clears only resolved ones
// - alert-response read clears latch when all clear
// - bits 1,0 trips drive pin, self-clear
// - release only at limit minus hysteresis
// - second role uses high flags only, hysteresis
// - offset ten-bit signed, integer plus quarters
// - offset added to remote, resets to zero
// - one-shot write in standby starts conversion
// - limits and hysteresis readable and writable
// - config bit 5 selects shared pin role
// - config bit 7 masks alarm in alarm role
module temp_limit_alarm_status (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire temp_limit_pkg::reg_req_s req_i,
   input wire logic alert_response_i,
   input wire temp_limit_pkg::local_sample_s local_i,
   input wire temp_limit_pkg::remote_sample_s remote_i,
   input wire logic adc_busy_i,
   output logic [7:0] reg_rdata_o,
   output logic convert_start_o,
   output logic standby_o,
   output logic range_ext_o,
   output logic overtemp_out_n_o,
   output logic overtemp_oe_o,
   output logic shared_pin_out_n_o,
   output logic shared_pin_oe_o
);
   import temp_limit_pkg::*;

   logic [7:0] cfg;
   logic [7:0] lim_local_high_flag;
   logic [7:0] lim_local_low_flag;
   logic [7:0] lim_remote_high_flag_hi;
   logic [7:0] lim_remote_high_flag_lo;
   logic [7:0] lim_remote_low_flag_hi;
   logic [7:0] lim_remote_low_flag_lo;
   logic [7:0] lim_rtherm;
   logic [7:0] lim_ltherm;
   logic [7:0] hyst;
   logic [7:0] ofs_hi;
   logic [7:0] ofs_lo;
   logic [7:0] local_val;
   logic [7:0] remote_val_hi;
   logic [7:0] remote_val_lo;
   logic local_high_cond;
   logic local_low_cond;
   logic remote_high_cond;
   logic remote_low_cond;
   logic open_cond;
   logic local_high_flag;
   logic local_low_flag;
   logic remote_high_flag;
   logic remote_low_flag;
   logic open_flag;
   logic [3:0] trip;
   logic [3:0] trip_upd;
   logic [9:0] trip_val [4];
   logic [9:0] trip_lim [4];
   alarm_state_e alarm_state;
   alarm_state_e next_alarm_state;
   logic [7:0] next_rdata;
   logic [9:0] remote_adj;
   logic [9:0] remote_lim_high;
   logic [9:0] remote_lim_low;
   logic status_rd;
   logic any_flag;
   logic any_cond;
   logic shot_req;

   // true while the trip must hold: above limit, or already tripped and above limit minus hysteresis
   function automatic logic trip_next(input logic cur, input logic [9:0] val,
                                      input logic [9:0] lim, input logic [7:0] hy);
      logic signed [11:0] rel;
      rel = $signed({2'b00, lim}) - $signed({2'b00, hy, 2'b00});
      trip_next = (val > lim) || (cur && ($signed({2'b00, val}) > rel));
   endfunction

   function automatic logic wr_hit(input reg_req_s r, input logic [7:0] a);
      wr_hit = r.wr && (r.addr == a);
   endfunction

   assign status_rd = req_i.rd && (req_i.addr == `ADDR_STATUS);
   // one-shot outside standby is dropped, written data never stored
   assign shot_req = wr_hit(req_i, `ADDR_ONE_SHOT) && cfg[`CFG_STANDBY_BIT];
   assign remote_lim_high = {lim_remote_high_flag_hi, lim_remote_high_flag_lo[7:6]};
   assign remote_lim_low = {lim_remote_low_flag_hi, lim_remote_low_flag_lo[7:6]};

   always_comb
   begin
      logic signed [11:0] sum;
      logic [11:0] top;
      sum = 12'sh000;
      top = cfg[`CFG_RANGE_BIT] ? `REMOTE_MAX_EXT : `REMOTE_MAX_BIN;
      sum = $signed({2'b00, remote_i.temp}) + $signed({{2{ofs_hi[7]}}, ofs_hi, ofs_lo[7:6]});
      // clamp keeps the result inside the active range rather than wrapping
      if (sum < 12'sh000)
      begin
         remote_adj = 10'h000;
      end
      else if (sum > $signed(top))
      begin
         remote_adj = top[9:0];
      end
      else
      begin
         remote_adj = sum[9:0];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         lim_local_high_flag <= `RST_HIGH_LIMIT;
         lim_local_low_flag <= `RST_ZERO;
         lim_remote_high_flag_hi <= `RST_HIGH_LIMIT;
         lim_remote_high_flag_lo <= `RST_ZERO;
         lim_remote_low_flag_hi <= `RST_ZERO;
         lim_remote_low_flag_lo <= `RST_ZERO;
         lim_rtherm <= `RST_OVERTEMP_OUT_N_LIMIT;
         lim_ltherm <= `RST_OVERTEMP_OUT_N_LIMIT;
      end
      else
      begin
         if (wr_hit(req_i, `ADDR_LOCAL_HIGH_FLAG_WR)) lim_local_high_flag <= req_i.wdata;
         if (wr_hit(req_i, `ADDR_LOCAL_LOW_FLAG_WR)) lim_local_low_flag <= req_i.wdata;
         if (wr_hit(req_i, `ADDR_REMOTE_HIGH_FLAG_HI_WR)) lim_remote_high_flag_hi <= req_i.wdata;
         if (wr_hit(req_i, `ADDR_REMOTE_HIGH_FLAG_LO)) lim_remote_high_flag_lo <= req_i.wdata & `FRAC_MASK;
         if (wr_hit(req_i, `ADDR_REMOTE_LOW_FLAG_HI_WR)) lim_remote_low_flag_hi <= req_i.wdata;
         if (wr_hit(req_i, `ADDR_REMOTE_LOW_FLAG_LO)) lim_remote_low_flag_lo <= req_i.wdata & `FRAC_MASK;
         if (wr_hit(req_i, `ADDR_RTHERM)) lim_rtherm <= req_i.wdata;
         if (wr_hit(req_i, `ADDR_LTHERM)) lim_ltherm <= req_i.wdata;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         hyst <= `RST_HYST;
         ofs_hi <= `RST_ZERO;
         ofs_lo <= `RST_ZERO;
         cfg <= `RST_ZERO;
      end
      else
      begin
         if (wr_hit(req_i, `ADDR_HYST)) hyst <= req_i.wdata;
         if (wr_hit(req_i, `ADDR_OFS_HI)) ofs_hi <= req_i.wdata;
         if (wr_hit(req_i, `ADDR_OFS_LO)) ofs_lo <= req_i.wdata & `FRAC_MASK;
         if (wr_hit(req_i, `ADDR_CFG_WR)) cfg <= req_i.wdata & `CFG_USED;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         local_val <= `RST_ZERO;
         remote_val_hi <= `RST_ZERO;
         remote_val_lo <= `RST_ZERO;
      end
      else
      begin
         if (local_i.valid) local_val <= local_i.temp;
         if (remote_i.valid)
         begin
            remote_val_hi <= remote_adj[9:2];
            remote_val_lo <= {remote_adj[1:0], 6'b000000};
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         local_high_cond <= 1'b0;
         local_low_cond <= 1'b0;
         remote_high_cond <= 1'b0;
         remote_low_cond <= 1'b0;
         open_cond <= 1'b0;
      end
      else
      begin
         if (local_i.valid)
         begin
            local_high_cond <= local_i.temp > lim_local_high_flag;
            local_low_cond <= local_i.temp <= lim_local_low_flag;
         end
         if (remote_i.valid)
         begin
            remote_high_cond <= remote_adj > remote_lim_high;
            remote_low_cond <= remote_adj <= remote_lim_low;
            open_cond <= remote_i.open;
         end
      end
   end

   // sticky, set beats the read clear
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         local_high_flag <= 1'b0;
         local_low_flag <= 1'b0;
         remote_high_flag <= 1'b0;
         remote_low_flag <= 1'b0;
         open_flag <= 1'b0;
      end
      else
      begin
         local_high_flag <= local_high_cond | (local_high_flag & ~status_rd);
         local_low_flag <= local_low_cond | (local_low_flag & ~status_rd);
         remote_high_flag <= remote_high_cond | (remote_high_flag & ~status_rd);
         remote_low_flag <= remote_low_cond | (remote_low_flag & ~status_rd);
         open_flag <= open_cond | (open_flag & ~status_rd);
      end
   end

   // trip channels: 0 local over-temp, 1 remote over-temp, 2 local high, 3 remote high
   assign trip_val[0] = {local_i.temp, 2'b00};
   assign trip_val[1] = {remote_adj[9:2], 2'b00};
   assign trip_val[2] = {local_i.temp, 2'b00};
   assign trip_val[3] = remote_adj;
   assign trip_lim[0] = {lim_ltherm, 2'b00};
   assign trip_lim[1] = {lim_rtherm, 2'b00};
   assign trip_lim[2] = {lim_local_high_flag, 2'b00};
   assign trip_lim[3] = remote_lim_high;
   assign trip_upd = {remote_i.valid, local_i.valid, remote_i.valid, local_i.valid};

   generate
      for (genvar g = 0; g < 4; g++)
      begin : g_trip
         always_ff @(posedge clk_i or negedge arst_n_i)
         begin
            if (!arst_n_i)
            begin
               trip[g] <= 1'b0;
            end
            else if (trip_upd[g])
            begin
               trip[g] <= trip_next(trip[g], trip_val[g], trip_lim[g], hyst);
            end
         end
      end
   endgenerate

   assign any_flag = local_high_flag | local_low_flag | remote_high_flag | remote_low_flag | open_flag;
   assign any_cond = local_high_cond | local_low_cond | remote_high_cond | remote_low_cond | open_cond;

   always_comb
   begin
      next_alarm_state = alarm_state;
      case (alarm_state)
         ALM_IDLE:
         begin
            if (any_flag) next_alarm_state = ALM_SET;
         end
         ALM_SET:
         begin
            if (alert_response_i && !any_flag && !any_cond) next_alarm_state = ALM_IDLE;
         end
         default:
         begin
            next_alarm_state = ALM_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         alarm_state <= ALM_IDLE;
      end
      else
      begin
         alarm_state <= next_alarm_state;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         overtemp_out_n_o <= 1'b1;
         overtemp_oe_o <= 1'b0;
      end
      else
      begin
         overtemp_out_n_o <= ~(trip[0] | trip[1]);
         overtemp_oe_o <= trip[0] | trip[1];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         shared_pin_out_n_o <= 1'b1;
         shared_pin_oe_o <= 1'b0;
      end
      else if (cfg[`CFG_ROLE_BIT])
      begin
         shared_pin_out_n_o <= ~(trip[2] | trip[3]);
         shared_pin_oe_o <= trip[2] | trip[3];
      end
      else
      begin
         shared_pin_out_n_o <= ~((alarm_state == ALM_SET) & ~cfg[`CFG_MASK_BIT]);
         shared_pin_oe_o <= (alarm_state == ALM_SET) & ~cfg[`CFG_MASK_BIT];
      end
   end

   // one-shot only in standby, data dropped
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         convert_start_o <= 1'b0;
         standby_o <= 1'b0;
         range_ext_o <= 1'b0;
      end
      else
      begin
         convert_start_o <= shot_req;
         standby_o <= cfg[`CFG_STANDBY_BIT];
         range_ext_o <= cfg[`CFG_RANGE_BIT];
      end
   end

   always_comb
   begin
      case (req_i.addr)
         `ADDR_LOCAL_VAL: next_rdata = local_val;
         `ADDR_REMOTE_VAL_HI: next_rdata = remote_val_hi;
         `ADDR_REMOTE_VAL_LO: next_rdata = remote_val_lo;
         `ADDR_STATUS: next_rdata = {adc_busy_i, local_high_flag, local_low_flag, remote_high_flag,
                                     remote_low_flag, open_flag, trip[1], trip[0]};
         `ADDR_CFG_RD: next_rdata = cfg;
         `ADDR_LOCAL_HIGH_FLAG_RD: next_rdata = lim_local_high_flag;
         `ADDR_LOCAL_LOW_FLAG_RD: next_rdata = lim_local_low_flag;
         `ADDR_REMOTE_HIGH_FLAG_HI_RD: next_rdata = lim_remote_high_flag_hi;
         `ADDR_REMOTE_LOW_FLAG_HI_RD: next_rdata = lim_remote_low_flag_hi;
         `ADDR_REMOTE_HIGH_FLAG_LO: next_rdata = lim_remote_high_flag_lo;
         `ADDR_REMOTE_LOW_FLAG_LO: next_rdata = lim_remote_low_flag_lo;
         `ADDR_OFS_HI: next_rdata = ofs_hi;
         `ADDR_OFS_LO: next_rdata = ofs_lo;
         `ADDR_RTHERM: next_rdata = lim_rtherm;
         `ADDR_LTHERM: next_rdata = lim_ltherm;
         `ADDR_HYST: next_rdata = hyst;
         default: next_rdata = `RST_ZERO;
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         reg_rdata_o <= `RST_ZERO;
      end
      else if (req_i.rd)
      begin
         reg_rdata_o <= next_rdata;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   property p_high_equal_quiet;
      local_i.valid && (local_i.temp == lim_local_high_flag) |=> !local_high_cond ##1 !local_high_flag || $past(local_high_flag);
   endproperty
   a_high_equal_quiet: assert property (p_high_equal_quiet) else $error("equal reading flagged high");

   property p_low_equal_trips;
      local_i.valid && (local_i.temp == lim_local_low_flag) |=> local_low_cond ##1 local_low_flag;
   endproperty
   a_low_equal_trips: assert property (p_low_equal_trips) else $error("equal reading not flagged low");

   property p_overtemp_pin;
      (trip[0] || trip[1]) |=> overtemp_oe_o && !overtemp_out_n_o;
   endproperty
   a_overtemp_pin: assert property (p_overtemp_pin) else $error("overtemp pin not driven");

   property p_trip_holds_in_band;
      trip[0] && local_i.valid && ($signed({4'h0, local_i.temp}) > $signed({4'h0, lim_ltherm}) - $signed({4'h0, hyst}))
         |=> trip[0];
   endproperty
   a_trip_holds_in_band: assert property (p_trip_holds_in_band) else $error("trip released inside hysteresis");

   property p_flag_sticky;
      local_high_flag && !status_rd |=> local_high_flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost without status read");

   property p_latch_sets;
      any_flag |=> alarm_state == ALM_SET;
   endproperty
   a_latch_sets: assert property (p_latch_sets) else $error("alarm latch not set");

   property p_latch_survives_read;
      (alarm_state == ALM_SET) && !alert_response_i |=> alarm_state == ALM_SET;
   endproperty
   a_latch_survives_read: assert property (p_latch_survives_read) else $error("latch cleared without response");

   property p_alarm_mask;
      !cfg[`CFG_ROLE_BIT] && cfg[`CFG_MASK_BIT] |=> !shared_pin_oe_o;
   endproperty
   a_alarm_mask: assert property (p_alarm_mask) else $error("masked alarm still driven");

   property p_second_role;
      cfg[`CFG_ROLE_BIT] && (trip[2] || trip[3]) |=> shared_pin_oe_o && !shared_pin_out_n_o;
   endproperty
   a_second_role: assert property (p_second_role) else $error("second overtemp pin not driven");

   sequence s_shot_req;
      shot_req;
   endsequence
   property p_one_shot;
      s_shot_req |=> convert_start_o ##1 (!convert_start_o || $past(shot_req));
   endproperty
   a_one_shot: assert property (p_one_shot) else $error("one-shot pulse wrong");

endmodule // temp_limit_alarm_status

/* dv/reg_host_model.sv */
`timescale 1ns/1ps
module reg_host_model (
   input wire logic clk_i,
   output temp_limit_pkg::reg_req_s req_o,
   output logic alert_response_o,
   input wire logic [7:0] rdata_i
);
   import temp_limit_pkg::*;
   initial
   begin
      req_o = '0;
      alert_response_o = 1'b0;
   end
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_i);
      // idle lines inverted so stale values never match by luck
      req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_i);
      req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      #1;
      d = rdata_i;
   endtask
   task automatic alert_ack();
      @(posedge clk_i);
      alert_response_o <= 1'b1;
      @(posedge clk_i);
      alert_response_o <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
   endtask
endmodule // reg_host_model

/* dv/tb_temp_limit_alarm_status.sv */
`timescale 1ns/1ps
`include "temp_limit_map.svh"
module tb_temp_limit_alarm_status;
   import temp_limit_pkg::*;
   logic clk_i;
   logic arst_n_i;
   reg_req_s req;
   logic alert_resp;
   local_sample_s loc;
   remote_sample_s rem;
   logic adc_busy;
   logic [7:0] rdata;
   logic conv_start;
   logic standby;
   logic range_ext;
   logic ot_n;
   logic ot_oe;
   logic sp_n;
   logic sp_oe;
   int error_cnt;
   int cmp_count;
   int cycles;

   temp_limit_alarm_status i_temp_limit_alarm_status (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .alert_response_i(alert_resp),
      .local_i(loc), .remote_i(rem), .adc_busy_i(adc_busy), .reg_rdata_o(rdata),
      .convert_start_o(conv_start), .standby_o(standby), .range_ext_o(range_ext),
      .overtemp_out_n_o(ot_n), .overtemp_oe_o(ot_oe), .shared_pin_out_n_o(sp_n),
      .shared_pin_oe_o(sp_oe)
   );
   reg_host_model i_reg_host_model (
      .clk_i(clk_i), .req_o(req), .alert_response_o(alert_resp), .rdata_i(rdata)
   );

   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(input string n, input logic e, input logic g);
      cmp_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      i_reg_host_model.reg_read(a, d);
      chk8($sformatf("reg %h", a), e, d);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_reg_host_model.reg_write(a, d);
   endtask
   // settle past the pin latency of both the trip and the alarm latch
   task automatic put_loc(input logic [7:0] t);
      @(posedge clk_i);
      loc <= '{valid: 1'b1, temp: t};
      @(posedge clk_i);
      loc.valid <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
   endtask
   task automatic put_rem(input logic op, input logic [9:0] t);
      @(posedge clk_i);
      rem <= '{valid: 1'b1, open: op, temp: t};
      @(posedge clk_i);
      rem.valid <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
   endtask

   task automatic t_reset();
      rd(`ADDR_STATUS, 8'h00);
      rd(`ADDR_HYST, 8'h0A);
      rd(`ADDR_OFS_HI, 8'h00);
      rd(`ADDR_OFS_LO, 8'h00);
      rd(`ADDR_LOCAL_HIGH_FLAG_RD, 8'h55);
      rd(8'hFE, 8'h00);
      wr(`ADDR_HYST, 8'h05);
      rd(`ADDR_HYST, 8'h05);
      wr(`ADDR_HYST, 8'h0A);
      wr(`ADDR_REMOTE_HIGH_FLAG_LO, 8'hFF);
      rd(`ADDR_REMOTE_HIGH_FLAG_LO, 8'hC0);
      wr(`ADDR_REMOTE_HIGH_FLAG_LO, 8'h00);
      chk1("sp_oe", 1'b0, sp_oe);
   endtask
   task automatic t_limits();
      put_loc(8'h55);
      rd(`ADDR_STATUS, 8'h00);
      put_loc(8'h56);
      chk1("sp_oe", 1'b1, sp_oe);
      chk1("sp_n", 1'b0, sp_n);
      rd(`ADDR_STATUS, 8'h41);
      rd(`ADDR_STATUS, 8'h41);
      put_loc(8'h20);
      rd(`ADDR_STATUS, 8'h40);
      rd(`ADDR_STATUS, 8'h00);
      chk1("sp_oe", 1'b1, sp_oe);
      i_reg_host_model.alert_ack();
      chk1("sp_oe", 1'b0, sp_oe);
      wr(`ADDR_LOCAL_LOW_FLAG_WR, 8'h20);
      rd(`ADDR_LOCAL_LOW_FLAG_RD, 8'h20);
      put_loc(8'h20);
      rd(`ADDR_STATUS, 8'h20);
      i_reg_host_model.alert_ack();
      chk1("sp_oe", 1'b1, sp_oe);
      put_loc(8'h21);
      rd(`ADDR_STATUS, 8'h20);
      rd(`ADDR_STATUS, 8'h00);
      wr(`ADDR_LOCAL_LOW_FLAG_WR, 8'h00);
      put_rem(1'b0, 10'h154);
      rd(`ADDR_STATUS, 8'h00);
      put_rem(1'b0, 10'h155);
      rd(`ADDR_STATUS, 8'h10);
      put_rem(1'b1, 10'h140);
      rd(`ADDR_STATUS, 8'h14);
      put_rem(1'b0, 10'h140);
      rd(`ADDR_STATUS, 8'h04);
      rd(`ADDR_STATUS, 8'h00);
      i_reg_host_model.alert_ack();
      chk1("sp_oe", 1'b0, sp_oe);
   endtask
   task automatic t_overtemp_out_n();
      wr(`ADDR_LTHERM, 8'h30);
      put_loc(8'h31);
      chk1("ot_oe", 1'b1, ot_oe);
      chk1("ot_n", 1'b0, ot_n);
      rd(`ADDR_STATUS, 8'h01);
      put_loc(8'h27);
      chk1("ot_oe", 1'b1, ot_oe);
      put_loc(8'h26);
      chk1("ot_oe", 1'b0, ot_oe);
      chk1("ot_n", 1'b1, ot_n);
      rd(`ADDR_STATUS, 8'h00);
      wr(`ADDR_RTHERM, 8'h30);
      put_rem(1'b0, 10'h0C4);
      chk1("ot_oe", 1'b1, ot_oe);
      rd(`ADDR_STATUS, 8'h02);
      put_rem(1'b0, 10'h098);
      chk1("ot_oe", 1'b0, ot_oe);
      wr(`ADDR_LTHERM, 8'h55);
      wr(`ADDR_RTHERM, 8'h55);
   endtask
   task automatic t_role();
      wr(`ADDR_CFG_WR, 8'h20);
      rd(`ADDR_CFG_RD, 8'h20);
      wr(`ADDR_LOCAL_LOW_FLAG_WR, 8'h20);
      put_loc(8'h10);
      chk1("sp_oe", 1'b0, sp_oe);
      put_loc(8'h60);
      chk1("sp_oe", 1'b1, sp_oe);
      chk1("sp_n", 1'b0, sp_n);
      put_loc(8'h4C);
      chk1("sp_oe", 1'b1, sp_oe);
      put_loc(8'h4B);
      chk1("sp_oe", 1'b0, sp_oe);
      rd(`ADDR_STATUS, 8'h60);
      rd(`ADDR_STATUS, 8'h00);
      i_reg_host_model.alert_ack();
      wr(`ADDR_LOCAL_LOW_FLAG_WR, 8'h00);
      wr(`ADDR_CFG_WR, 8'h80);
      put_loc(8'h60);
      chk1("sp_oe", 1'b0, sp_oe);
      wr(`ADDR_CFG_WR, 8'hA0);
      put_loc(8'h60);
      chk1("sp_oe", 1'b1, sp_oe);
      wr(`ADDR_CFG_WR, 8'h00);
      put_loc(8'h30);
      chk1("sp_oe", 1'b1, sp_oe);
      rd(`ADDR_STATUS, 8'h40);
      i_reg_host_model.alert_ack();
      chk1("sp_oe", 1'b0, sp_oe);
   endtask
   task automatic t_offset();
      put_rem(1'b0, 10'h141);
      rd(`ADDR_REMOTE_VAL_HI, 8'h50);
      rd(`ADDR_REMOTE_VAL_LO, 8'h40);
      wr(`ADDR_OFS_HI, 8'hFF);
      wr(`ADDR_OFS_LO, 8'hBF);
      rd(`ADDR_OFS_LO, 8'h80);
      put_rem(1'b0, 10'h141);
      rd(`ADDR_REMOTE_VAL_HI, 8'h4F);
      rd(`ADDR_REMOTE_VAL_LO, 8'hC0);
      wr(`ADDR_OFS_HI, 8'h04);
      wr(`ADDR_OFS_LO, 8'h40);
      put_rem(1'b0, 10'h141);
      rd(`ADDR_REMOTE_VAL_HI, 8'h54);
      rd(`ADDR_REMOTE_VAL_LO, 8'h80);
      wr(`ADDR_OFS_HI, 8'h00);
      wr(`ADDR_OFS_LO, 8'h00);
   endtask
   task automatic t_oneshot();
      wr(`ADDR_ONE_SHOT, 8'h5A);
      #1;
      chk1("conv_start", 1'b0, conv_start);
      wr(`ADDR_CFG_WR, 8'h40);
      @(posedge clk_i);
      #1;
      chk1("standby", 1'b1, standby);
      wr(`ADDR_ONE_SHOT, 8'hA5);
      #1;
      chk1("conv_start", 1'b1, conv_start);
      @(posedge clk_i);
      #1;
      chk1("conv_start", 1'b0, conv_start);
      rd(`ADDR_ONE_SHOT, 8'h00);
      adc_busy <= 1'b1;
      rd(`ADDR_STATUS, 8'h80);
      adc_busy <= 1'b0;
      wr(`ADDR_CFG_WR, 8'h04);
      @(posedge clk_i);
      #1;
      chk1("range_ext", 1'b1, range_ext);
      rd(`ADDR_LOCAL_HIGH_FLAG_RD, 8'h55);
      wr(`ADDR_CFG_WR, 8'h00);
   endtask

   task automatic finish_test();
      if (error_cnt == 0 && cmp_count > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // bound well above the few hundred cycles the sequence needs
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         finish_test();
      end
   end

   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial
   begin
      arst_n_i = 1'b0;
      loc = '0;
      rem = '0;
      adc_busy = 1'b0;
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      t_reset();
      t_limits();
      t_overtemp_out_n();
      t_role();
      t_offset();
      t_oneshot();
      finish_test();
   end
endmodule // tb_temp_limit_alarm_status
